// *** verilog/gsb_map.svh ***
// gsb_map.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name; 32-bit AXI4-Lite word registers
`ifndef GSB_MAP_SVH
`define GSB_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define GSB_OFS_MODE_LO   12'h000
`define GSB_OFS_MODE_HI   12'h004
`define GSB_OFS_OUT_VAL   12'h008
`define GSB_OFS_PULL_SEL  12'h00C
`define GSB_OFS_PAD_READ  12'h010
`define GSB_OFS_NET_STATE 12'h014

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define GSB_NUM_PADS      10
`define GSB_IND_PAD       0
`define GSB_MON_PAD       4
`define GSB_MODE_INPUT    2'h0
`define GSB_MODE_OUTPUT   2'h1
`define GSB_MODE_ALT      2'h2
`define GSB_RST_OUT_VAL   10'h000
`define GSB_RST_PULL_SEL  10'h000
`define GSB_RST_NET_STATE 3'h0
`define GSB_RESP_OKAY     2'h0
`define GSB_RESP_SLVERR   2'h2

// ----------------------------------------------------------------
// timing (ms) and clock rate
// ----------------------------------------------------------------
`define GSB_CLK_HZ        100000000
`define GSB_TICK_HZ       1000
`define GSB_FAST_PER_MS   1000
`define GSB_FAST_ON_MS    500
`define GSB_SLOW_PER_MS   3000
`define GSB_SLOW_ON_MS    300
`define GSB_TICK_CYC      (`GSB_CLK_HZ / `GSB_TICK_HZ)

`endif

// *** verilog/gsb_pkg.sv ***
// gsb_pkg.sv: types shared by the port block and its blinker
// assumes: gsb_map.svh gives the numbers
package gsb_pkg;

  // ----------------------------------------------------------------
  // service states shown on the indicator
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    GSB_NET_OFF,
    GSB_NET_SEARCH,
    GSB_NET_REGISTERED,
    GSB_NET_CALL
  } gsb_net_t;

  typedef struct packed
  {
    logic [9:0] out_en;
    logic [9:0] out_val;
    logic [9:0] pull_up;
    logic [9:0] pull_down;
  } gsb_pad_drv_t;

endpackage

// *** verilog/gsb_blinker.sv ***
// gsb_blinker.sv: lamp pattern generator for the service indicator
// assumes: aclk 100 MHz; net_state from logic on the same clock
`timescale 1ns/1ps
`include "gsb_map.svh"
module gsb_blinker
#(
  parameter int TICK_CYC = `GSB_TICK_CYC
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire gsb_pkg::gsb_net_t net_state,
  output logic                  lamp_on
);

  logic [31:0]       pre_ff;
  logic [31:0]       nxt_pre;
  logic [11:0]       ms_ff;
  logic [11:0]       nxt_ms;
  gsb_pkg::gsb_net_t last_ff;
  gsb_pkg::gsb_net_t nxt_last;
  logic              lamp_ff;
  logic              nxt_lamp;
  logic              tick;

  assign lamp_on = lamp_ff;

  always_comb
  begin
    tick     = (pre_ff == 32'(TICK_CYC - 1));
    nxt_pre  = tick ? 32'h0000_0000 : pre_ff + 32'h0000_0001;
    nxt_ms   = ms_ff;
    nxt_last = net_state;
    if (net_state != last_ff)
    begin
      nxt_pre = 32'h0000_0000;
      nxt_ms  = 12'h000;
    end
    else if (tick)
    begin
      unique case (net_state)
        gsb_pkg::GSB_NET_SEARCH:
          nxt_ms = (ms_ff == 12'(`GSB_FAST_PER_MS - 1)) ? 12'h000
                   : ms_ff + 12'h001;
        gsb_pkg::GSB_NET_REGISTERED:
          nxt_ms = (ms_ff == 12'(`GSB_SLOW_PER_MS - 1)) ? 12'h000
                   : ms_ff + 12'h001;
        default:
          nxt_ms = 12'h000;
      endcase
    end
    unique case (nxt_last)
      gsb_pkg::GSB_NET_OFF:        nxt_lamp = 1'b0;
      gsb_pkg::GSB_NET_CALL:       nxt_lamp = 1'b1;
      gsb_pkg::GSB_NET_SEARCH:
        nxt_lamp = (nxt_ms < 12'(`GSB_FAST_ON_MS));
      gsb_pkg::GSB_NET_REGISTERED:
        nxt_lamp = (nxt_ms < 12'(`GSB_SLOW_ON_MS));
      default:                     nxt_lamp = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_ff  <= 32'h0000_0000;
      ms_ff   <= 12'h000;
      last_ff <= gsb_pkg::GSB_NET_OFF;
      lamp_ff <= 1'b0;
    end
    else
    begin
      pre_ff  <= nxt_pre;
      ms_ff   <= nxt_ms;
      last_ff <= nxt_last;
      lamp_ff <= nxt_lamp;
    end
  end

endmodule

// *** verilog/gsb_pad_sync.sv ***
// gsb_pad_sync.sv: two-stage synchroniser for the pad input levels
// assumes: pad levels are asynchronous to aclk
`timescale 1ns/1ps
module gsb_pad_sync
#(
  parameter int WIDTH = 10
)
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  assign sync_out = sync_ff;

  // first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

endmodule

// *** verilog/gsb_gpio_port.sv ***
// gsb_gpio_port.sv: ten-pad GPIO port with service indicator blinker
// assumes: AXI4-Lite master on aclk; pads resolved outside from enables
//
// How it works
// - each pad picks input, output or alternate
// - input pads read the synchronised pad level
// - output pads drive written value, read back
// - alternate pads follow their internal function
// - pad one indicator, pad five transmit monitor
// - reset leaves all pads input, pulled down
// - per-pad pull-up or pull-down selection
// - outputs drive push-pull, both levels
// - indicator pin drives the inverted lamp
// - off steady dark, call steady lit
// - searching blinks 1 s period, 0.5 s lit
// - registered blinks 3 s period, 0.3 s lit
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "gsb_map.svh"
module gsb_gpio_port
#(
  parameter int NUM_PADS = `GSB_NUM_PADS,
  parameter int TICK_CYC = `GSB_TICK_CYC
)
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [11:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [11:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [NUM_PADS-1:0] pad_in,
  output logic [NUM_PADS-1:0]      pad_out,
  output logic [NUM_PADS-1:0]      pad_oe,
  output logic [NUM_PADS-1:0]      pad_pull_up,
  output logic [NUM_PADS-1:0]      pad_pull_down,
  input  wire logic                rf_transmit_monitor
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2*NUM_PADS-1:0] mode_ff;
  logic [2*NUM_PADS-1:0] nxt_mode;
  logic [NUM_PADS-1:0]   outv_ff;
  logic [NUM_PADS-1:0]   nxt_outv;
  logic [NUM_PADS-1:0]   pull_ff;
  logic [NUM_PADS-1:0]   nxt_pull;
  gsb_pkg::gsb_net_t     net_ff;
  gsb_pkg::gsb_net_t     nxt_net;
  logic                  aw_ff;
  logic                  nxt_aw;
  logic [11:0]           awaddr_ff;
  logic [11:0]           nxt_awaddr;
  logic                  w_ff;
  logic                  nxt_w;
  logic [31:0]           wdata_ff;
  logic [31:0]           nxt_wdata;
  logic [3:0]            wstrb_ff;
  logic [3:0]            nxt_wstrb;
  logic                  bvalid_ff;
  logic                  nxt_bvalid;
  logic [1:0]            bresp_ff;
  logic [1:0]            nxt_bresp;
  logic                  rvalid_ff;
  logic                  nxt_rvalid;
  logic [31:0]           rdata_ff;
  logic [31:0]           nxt_rdata;
  logic [1:0]            rresp_ff;
  logic [1:0]            nxt_rresp;
  logic [NUM_PADS-1:0]   pad_sync;
  logic                  mon_sync;
  logic                  mon_meta_ff;
  logic                  mon_ff;
  logic                  lamp_on;
  logic [NUM_PADS-1:0]   pad_rd;
  gsb_pkg::gsb_pad_drv_t drv_ff;
  gsb_pkg::gsb_pad_drv_t nxt_drv;
  logic                  do_wr;

  // merge a write word into a register under byte strobes
  function automatic logic [31:0] wr_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        res[8*b +: 8] = new_v[8*b +: 8];
    return res;
  endfunction

  // two-bit mode field of one pad
  function automatic logic [1:0] pad_mode(input logic [2*NUM_PADS-1:0] m,
                                          input int                    p);
    return m[2*p +: 2];
  endfunction

  // ----------------------------------------------------------------
  // pad input synchronisers and blinker
  // ----------------------------------------------------------------
  gsb_pad_sync #(.WIDTH(NUM_PADS)) u_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pad_in),
    .sync_out (pad_sync)
  );

  gsb_blinker #(.TICK_CYC(TICK_CYC)) u_blink
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .net_state (net_ff),
    .lamp_on   (lamp_on)
  );

  // monitor comes from radio logic in another domain, so it is synced
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mon_meta_ff <= 1'b0;
      mon_ff      <= 1'b0;
    end
    else
    begin
      mon_meta_ff <= rf_transmit_monitor;
      mon_ff      <= mon_meta_ff;
    end
  end
  assign mon_sync = mon_ff;

  // ----------------------------------------------------------------
  // pad drive
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_drv = '0;
    for (int p = 0; p < NUM_PADS; p++)
    begin
      nxt_drv.pull_up[p]   = pull_ff[p];
      nxt_drv.pull_down[p] = ~pull_ff[p];
      unique case (pad_mode(mode_ff, p))
        `GSB_MODE_OUTPUT:
        begin
          nxt_drv.out_en[p]  = 1'b1;
          nxt_drv.out_val[p] = outv_ff[p];
        end
        // alternate on a pad without a function stays undriven
        `GSB_MODE_ALT:
        begin
          if (p == `GSB_IND_PAD)
          begin
            nxt_drv.out_en[p]  = 1'b1;
            nxt_drv.out_val[p] = ~lamp_on;
          end
          else if (p == `GSB_MON_PAD)
          begin
            nxt_drv.out_en[p]  = 1'b1;
            nxt_drv.out_val[p] = mon_sync;
          end
        end
        default:
        begin
          // spare mode 3 behaves as input
          nxt_drv.out_en[p]  = 1'b0;
          nxt_drv.out_val[p] = 1'b0;
        end
      endcase
    end
  end

  // registered so mode and level reach the pad together
  assign pad_out       = drv_ff.out_val;
  assign pad_oe        = drv_ff.out_en;
  assign pad_pull_up   = drv_ff.pull_up;
  assign pad_pull_down = drv_ff.pull_down;

  // input pads show the pad, output pads the driven value
  always_comb
  begin
    for (int p = 0; p < NUM_PADS; p++)
      pad_rd[p] = (pad_mode(mode_ff, p) == `GSB_MODE_OUTPUT) ? outv_ff[p]
                  : pad_sync[p];
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // one write and one read at a time; readies fall while an answer waits
  assign s_axi_awready = ~aw_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb
  begin
    nxt_aw     = aw_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w      = w_ff;
    nxt_wdata  = wdata_ff;
    nxt_wstrb  = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    nxt_mode   = mode_ff;
    nxt_outv   = outv_ff;
    nxt_pull   = pull_ff;
    nxt_net    = net_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw     = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w     = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    // commit only once address and data are both held
    do_wr = aw_ff & w_ff;
    if (do_wr)
    begin
      nxt_aw     = 1'b0;
      nxt_w      = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = `GSB_RESP_OKAY;
      unique case ({awaddr_ff[11:2], 2'b00})
        `GSB_OFS_MODE_LO:
          nxt_mode[9:0] = 10'(wr_merge(32'(mode_ff[9:0]), wdata_ff,
                                       wstrb_ff));
        `GSB_OFS_MODE_HI:
          nxt_mode[19:10] = 10'(wr_merge(32'(mode_ff[19:10]), wdata_ff,
                                         wstrb_ff));
        `GSB_OFS_OUT_VAL:
          nxt_outv = 10'(wr_merge(32'(outv_ff), wdata_ff, wstrb_ff));
        `GSB_OFS_PULL_SEL:
          nxt_pull = 10'(wr_merge(32'(pull_ff), wdata_ff, wstrb_ff));
        `GSB_OFS_NET_STATE:
        begin
          // a refused state code leaves the indicator as it was
          if (wstrb_ff[0] && wdata_ff[2:0] <= 3'h3)
            nxt_net = gsb_pkg::gsb_net_t'(wdata_ff[2:0]);
          else if (wstrb_ff[0])
            nxt_bresp = `GSB_RESP_SLVERR;
        end
        `GSB_OFS_PAD_READ: ;
        default:
          nxt_bresp = `GSB_RESP_SLVERR;
      endcase
    end
    // answer leaves once taken; no write starts while it waits
    if (bvalid_ff && s_axi_bready)
      nxt_bvalid = 1'b0;
  end

  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (rvalid_ff && s_axi_rready)
      nxt_rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = `GSB_RESP_OKAY;
      nxt_rdata  = 32'h0000_0000;
      unique case ({s_axi_araddr[11:2], 2'b00})
        `GSB_OFS_MODE_LO:   nxt_rdata = 32'(mode_ff[9:0]);
        `GSB_OFS_MODE_HI:   nxt_rdata = 32'(mode_ff[19:10]);
        `GSB_OFS_OUT_VAL:   nxt_rdata = 32'(outv_ff);
        `GSB_OFS_PULL_SEL:  nxt_rdata = 32'(pull_ff);
        `GSB_OFS_PAD_READ:  nxt_rdata = 32'(pad_rd);
        `GSB_OFS_NET_STATE: nxt_rdata = 32'(net_ff);
        // unmapped reads answer zero with an error
        default:            nxt_rresp = `GSB_RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_ff   <= '0;
      outv_ff   <= `GSB_RST_OUT_VAL;
      pull_ff   <= `GSB_RST_PULL_SEL;
      net_ff    <= gsb_pkg::GSB_NET_OFF;
      aw_ff     <= 1'b0;
      awaddr_ff <= 12'h000;
      w_ff      <= 1'b0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `GSB_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= `GSB_RESP_OKAY;
      // pads come up as inputs pulled down, before any write
      drv_ff    <= '{out_en: '0, out_val: '0, pull_up: '0,
                     pull_down: '1};
    end
    else
    begin
      mode_ff   <= nxt_mode;
      outv_ff   <= nxt_outv;
      pull_ff   <= nxt_pull;
      net_ff    <= nxt_net;
      aw_ff     <= nxt_aw;
      awaddr_ff <= nxt_awaddr;
      w_ff      <= nxt_w;
      wdata_ff  <= nxt_wdata;
      wstrb_ff  <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
      drv_ff    <= nxt_drv;
    end
  end

endmodule

// *** sim/gsb_gpio_port_asserts.sv ***
// gsb_gpio_port_asserts.sv: pin and bus checks for the GPIO port
// assumes: bound to gsb_gpio_port; one clock, synchronous reset
`timescale 1ns/1ps
module gsb_gpio_port_asserts
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [9:0]  pad_oe,
  input wire logic [9:0]  pad_pull_up,
  input wire logic [9:0]  pad_pull_down
);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // reset itself is the cause here, so no disable
  reset_pads_a: assert property (disable iff (1'b0)
    !aresetn |=> pad_oe == 10'h000 && pad_pull_down == 10'h3FF)
    else $error("pads not input pulled down after reset");
  pull_exclusive_a: assert property (
    (pad_pull_up ^ pad_pull_down) == 10'h3FF)
    else $error("pull up and pull down not exclusive");
  oe_by_write_a: assert property (
    $changed(pad_oe) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pad direction changed without a write");
  pull_by_write_a: assert property (
    $changed(pad_pull_up) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("pull selection changed without a write");
  wr_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  wr_resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  rd_data_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

// *** sim/gsb_pad_partner.sv ***
// gsb_pad_partner.sv: external devices and pulls resolving pad levels
// assumes: one of pull up or pull down is always on
`timescale 1ns/1ps
module gsb_pad_partner
(
  input  wire logic [9:0] pad_out,
  input  wire logic [9:0] pad_oe,
  input  wire logic [9:0] pad_pull_up,
  input  wire logic [9:0] ext_en,
  input  wire logic [9:0] ext_val,
  output logic      [9:0] pad_level
);
  // ----------------------------------------------------------------
  // wire resolution: port drive, else device, else pull
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 10; i++)
      pad_level[i] = pad_oe[i] ? pad_out[i] :
                     (ext_en[i] ? ext_val[i] : pad_pull_up[i]);
  end
endmodule

// *** sim/tb_gsb_gpio_port.sv ***
// tb_gsb_gpio_port.sv: self-checking bench for the GPIO port
// assumes: short prescale TICK_CYC=10, so 1 s is 10000 cycles
`timescale 1ns/1ps
`include "gsb_map.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_gsb_gpio_port;
  localparam int TK = 10;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, rf_transmit_monitor = 1'b0;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down;
  logic [9:0]  ext_en = 10'h000, ext_val = 10'h000;
  int          err_count = 0, samples_checked = 0, cycles = 0;

  gsb_gpio_port #(.TICK_CYC(TK)) DUT (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in,
    .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down, .rf_transmit_monitor);
  gsb_pad_partner u_far (.pad_out, .pad_oe, .pad_pull_up, .ext_en,
    .ext_val, .pad_level(pad_in));

  always #5 aclk = ~aclk;

  // ----------------------------------------------------------------
  // bus tasks: readies looked at mid-cycle, drive at rising edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, da, dw, tb;
    logic [1:0] r;
    da = 1'b0;
    dw = 1'b0;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(da && dw))
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    while (!tb)
    begin
      @(negedge aclk);
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end
    `CHK("bresp", er, r)
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!t)
    begin
      @(negedge aclk);
      t = s_axi_arvalid & s_axi_arready;
      @(posedge aclk);
    end
    s_axi_arvalid <= 1'b0;
    t = 1'b0;
    while (!t)
    begin
      @(negedge aclk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end
    `CHK("rresp", er, r)
    `CHK("rdata", e, d)
  endtask

  // length of a run of the indicator pin at one level
  task automatic run(input logic lvl, input int e);
    int n;
    n = 0;
    @(negedge aclk);
    while (pad_out[0] === lvl)
    begin
      n++;
      @(negedge aclk);
    end
    `CHK("run length", 1'b1, (n >= e - 12 && n <= e + 12))
    @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    `CHK("oe", 10'h000, pad_oe)
    `CHK("pull down", 10'h3FF, pad_pull_down)
    rd(`GSB_OFS_MODE_LO, 32'h0, `GSB_RESP_OKAY);
    rd(`GSB_OFS_MODE_HI, 32'h0, `GSB_RESP_OKAY);
    rd(`GSB_OFS_PULL_SEL, 32'h0, `GSB_RESP_OKAY);
    rd(`GSB_OFS_PAD_READ, 32'h0, `GSB_RESP_OKAY);
  endtask

  task automatic t_output;
    ext_en <= 10'h3FF;
    ext_val <= 10'h15A;
    wr(`GSB_OFS_MODE_LO, 32'h155, `GSB_RESP_OKAY);
    wr(`GSB_OFS_MODE_HI, 32'h155, `GSB_RESP_OKAY);
    wr(`GSB_OFS_OUT_VAL, 32'h2A5, `GSB_RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("oe", 10'h3FF, pad_oe)
    `CHK("out", 10'h2A5, pad_out)
    rd(`GSB_OFS_PAD_READ, 32'h2A5, `GSB_RESP_OKAY);
  endtask

  task automatic t_input;
    ext_en <= 10'h000;
    wr(`GSB_OFS_MODE_LO, 32'h0, `GSB_RESP_OKAY);
    wr(`GSB_OFS_MODE_HI, 32'h0, `GSB_RESP_OKAY);
    wr(`GSB_OFS_PULL_SEL, 32'h0F0, `GSB_RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("pull up", 10'h0F0, pad_pull_up)
    rd(`GSB_OFS_PAD_READ, 32'h0F0, `GSB_RESP_OKAY);
    ext_en <= 10'h3FF;
    ext_val <= 10'h136;
    repeat (4) @(posedge aclk);
    rd(`GSB_OFS_PAD_READ, 32'h136, `GSB_RESP_OKAY);
  endtask

  task automatic t_alt;
    rf_transmit_monitor <= 1'b1;
    wr(`GSB_OFS_MODE_LO, 32'h20A, `GSB_RESP_OKAY);
    repeat (5) @(posedge aclk);
    `CHK("oe", 10'h011, pad_oe & 10'h013)
    `CHK("pin1 off", 1'b1, pad_out[0])
    `CHK("pin5", 1'b1, pad_out[4])
    rf_transmit_monitor <= 1'b0;
    wr(`GSB_OFS_NET_STATE, 32'h3, `GSB_RESP_OKAY);
    repeat (5) @(posedge aclk);
    `CHK("pin5", 1'b0, pad_out[4])
    `CHK("pin1 call", 1'b0, pad_out[0])
    wr(`GSB_OFS_NET_STATE, 32'h4, `GSB_RESP_SLVERR);
    rd(`GSB_OFS_NET_STATE, 32'h3, `GSB_RESP_OKAY);
    s_axi_wstrb <= 4'h0;
    wr(`GSB_OFS_NET_STATE, 32'h1, `GSB_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`GSB_OFS_NET_STATE, 32'h3, `GSB_RESP_OKAY);
    rd(12'h018, 32'h0, `GSB_RESP_SLVERR);
  endtask

  task automatic t_blink;
    wr(`GSB_OFS_NET_STATE, 32'h1, `GSB_RESP_OKAY);
    run(1'b0, `GSB_FAST_ON_MS * TK);
    run(1'b1, (`GSB_FAST_PER_MS - `GSB_FAST_ON_MS) * TK);
    run(1'b0, `GSB_FAST_ON_MS * TK);
    repeat (1000) @(posedge aclk);
    // mid dark phase: new state must relight at once
    wr(`GSB_OFS_NET_STATE, 32'h2, `GSB_RESP_OKAY);
    run(1'b1, 2);
    run(1'b0, `GSB_SLOW_ON_MS * TK);
    run(1'b1, (`GSB_SLOW_PER_MS - `GSB_SLOW_ON_MS) * TK);
  endtask

  // reset in mid-run must bring back the start-up pad state
  task automatic t_rerst;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("oe", 10'h000, pad_oe)
    `CHK("pull down", 10'h3FF, pad_pull_down)
    rd(`GSB_OFS_MODE_LO, 32'h0, `GSB_RESP_OKAY);
    rd(`GSB_OFS_NET_STATE, 32'h0, `GSB_RESP_OKAY);
  endtask

  // ----------------------------------------------------------------
  // sequence, hang limit and verdict
  // ----------------------------------------------------------------
  task automatic results;
    if (err_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      err_count++;
      results();
    end
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_output();
    t_input();
    t_alt();
    t_blink();
    t_rerst();
    results();
  end
endmodule

bind gsb_gpio_port gsb_gpio_port_asserts u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pad_oe,
  .pad_pull_up, .pad_pull_down);
